// ---- logic/usb_suspend_firmware_agent.sv ----
// Firmware end: activity polling, suspend entry, register save, resume drive.
`include "usb_susp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module usb_suspend_firmware_agent #(
    parameter int MS_CYCLES = `SR_MS_CYCLES
) (
    input  wire logic                      sys_clk,
    input  wire logic                      sys_rst,
    usb_susp_if.firmware                   link,
    input  wire logic                      supply_is_5v,
    input  wire usb_susp_pkg::sleep_mode_t sleep_mode_sel,
    input  wire logic                      remote_wake_req,
    output logic                           suspended,
    output logic                           resume_busy
);
    usb_susp_pkg::fw_state_t st_ff;
    usb_susp_pkg::fw_state_t nxt_st;
    logic [7:0] save_ff [0:6];
    logic [7:0] nxt_save [0:6];
    logic [3:0] idx_ff;
    logic [3:0] nxt_idx;
    logic [3:0] ms_ff;
    logic [3:0] nxt_ms;
    logic       reg_sel_ff;
    logic       nxt_reg_sel;
    logic       wr_ff, rd_ff, sreq_ff, nxt_wr, nxt_rd, nxt_sreq;
    logic [3:0] addr_ff, nxt_addr;
    logic [7:0] wdata_ff, nxt_wdata;
    logic       susp_ff, busy_ff;
    logic       ms_tick;
    logic       want_save;

    ms_tick_divider #(.DIVIDE(MS_CYCLES)) u_tick (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .tick    (ms_tick)
    );

    assign want_save = (sleep_mode_sel != usb_susp_pkg::SLEEP_TWO_WIRE);

    // Sequences firmware register accesses, at most one per cycle; FW_RESTORE writes one register per cycle in a single state.
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            nxt_save[i] = save_ff[i];
        end
        nxt_st = st_ff;  nxt_idx = idx_ff;  nxt_ms = ms_ff;
        nxt_reg_sel = reg_sel_ff;
        nxt_wr = 1'b0;  nxt_rd = 1'b0;  nxt_sreq = 1'b0;
        nxt_addr = addr_ff;  nxt_wdata = 8'h00;
        case (st_ff)
            usb_susp_pkg::FW_INIT_CTL0: begin
                nxt_wr = 1'b1;
                nxt_addr = `SR_IDX_CTL_FIRST;
                nxt_wdata[`SR_CTL0_WAKE_EN_BIT] = 1'b1;
                nxt_reg_sel = supply_is_5v;
                nxt_st = usb_susp_pkg::FW_INIT_CTL1;
            end
            usb_susp_pkg::FW_INIT_CTL1: begin
                nxt_wr = 1'b1;
                nxt_addr = `SR_IDX_CTL_SECOND;
                nxt_wdata[`SR_CTL1_REG_SEL_BIT] = reg_sel_ff;
                nxt_st = usb_susp_pkg::FW_IDLE;
            end
            usb_susp_pkg::FW_IDLE: begin
                if (remote_wake_req) begin
                    nxt_wr = 1'b1;
                    nxt_addr = `SR_IDX_XCVR_FIRST;
                    nxt_wdata[`SR_XCVR0_OVR_EN_BIT] = 1'b1;
                    nxt_wdata[`SR_XCVR0_LEVEL_BIT] = 1'b1;
                    nxt_st = usb_susp_pkg::FW_DRIVE_J;
                end else if (ms_tick) begin
                    nxt_rd = 1'b1;
                    nxt_addr = `SR_IDX_CTL_SECOND;
                    nxt_st = usb_susp_pkg::FW_POLL_WAIT;
                end
            end
            usb_susp_pkg::FW_POLL_WAIT: begin
                if (link.reg_rvalid) begin
                    if (link.reg_rdata[`SR_CTL1_ACTIVITY_BIT]) begin
                        nxt_ms = 4'h0;
                        nxt_st = usb_susp_pkg::FW_POLL_CLR;
                    end else if (ms_ff + 4'h1 >= `SR_IDLE_MS) begin
                        nxt_ms = 4'h0;
                        nxt_idx = `SR_FIRST_VOLATILE;
                        nxt_st = want_save ? usb_susp_pkg::FW_SAVE_RD
                                           : usb_susp_pkg::FW_SLEEP_REQ;
                    end else begin
                        nxt_ms = ms_ff + 4'h1;
                        nxt_st = usb_susp_pkg::FW_IDLE;
                    end
                end
            end
            usb_susp_pkg::FW_POLL_CLR: begin
                // Clearing keeps the regulator selection untouched.
                nxt_wr = 1'b1;
                nxt_addr = `SR_IDX_CTL_SECOND;
                nxt_wdata[`SR_CTL1_REG_SEL_BIT] = reg_sel_ff;
                nxt_st = usb_susp_pkg::FW_IDLE;
            end
            usb_susp_pkg::FW_SAVE_RD: begin
                nxt_rd = 1'b1;
                nxt_addr = idx_ff;
                nxt_st = usb_susp_pkg::FW_SAVE_WAIT;
            end
            usb_susp_pkg::FW_SAVE_WAIT: begin
                if (link.reg_rvalid) begin
                    nxt_save[3'(idx_ff - `SR_FIRST_VOLATILE)] = link.reg_rdata;
                    nxt_idx = idx_ff + 4'h1;
                    nxt_st = (idx_ff == `SR_NREG - 4'h1) ? usb_susp_pkg::FW_SLEEP_REQ
                                                         : usb_susp_pkg::FW_SAVE_RD;
                end
            end
            usb_susp_pkg::FW_SLEEP_REQ: begin
                nxt_sreq = 1'b1;
                nxt_st = usb_susp_pkg::FW_SLEEPING;
            end
            usb_susp_pkg::FW_SLEEPING: begin
                if (link.wake_irq) begin
                    nxt_idx = `SR_FIRST_VOLATILE;
                    nxt_st = want_save ? usb_susp_pkg::FW_RESTORE : usb_susp_pkg::FW_IDLE;
                end
            end
            usb_susp_pkg::FW_RESTORE: begin
                nxt_wr = 1'b1;
                nxt_addr = idx_ff;
                nxt_wdata = save_ff[3'(idx_ff - `SR_FIRST_VOLATILE)];
                nxt_idx = idx_ff + 4'h1;
                if (idx_ff == `SR_NREG - 4'h1) begin
                    nxt_st = usb_susp_pkg::FW_IDLE;
                end
            end
            usb_susp_pkg::FW_DRIVE_J: begin
                // J stood one cycle; now K with the override kept on.
                nxt_wr = 1'b1;
                nxt_addr = `SR_IDX_XCVR_FIRST;
                nxt_wdata[`SR_XCVR0_OVR_EN_BIT] = 1'b1;
                nxt_ms = 4'h0;
                nxt_st = usb_susp_pkg::FW_DRIVE_K;
            end
            usb_susp_pkg::FW_DRIVE_K: begin
                // Ten ticks of a free-running divider give 9 to 10 ms.
                if (ms_tick) begin
                    nxt_ms = ms_ff + 4'h1;
                    if (ms_ff + 4'h1 >= `SR_K_HOLD_MS) begin
                        nxt_st = usb_susp_pkg::FW_RELEASE;
                    end
                end
            end
            usb_susp_pkg::FW_RELEASE: begin
                nxt_wr = 1'b1;
                nxt_addr = `SR_IDX_XCVR_FIRST;
                nxt_ms = 4'h0;
                nxt_st = usb_susp_pkg::FW_IDLE;
            end
            default: begin
                nxt_st = usb_susp_pkg::FW_INIT_CTL0;
            end
        endcase
    end

    // Registers the sequencer and every output toward the device except sleep_mode, which passes straight through.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 7; i++) begin
                save_ff[i] <= 8'h00;
            end
            st_ff <= usb_susp_pkg::FW_INIT_CTL0;
            idx_ff <= 4'h0;  ms_ff <= 4'h0;  reg_sel_ff <= 1'b0;
            wr_ff <= 1'b0;  rd_ff <= 1'b0;  sreq_ff <= 1'b0;
            addr_ff <= 4'h0;  wdata_ff <= 8'h00;
            susp_ff <= 1'b0;  busy_ff <= 1'b0;
        end else begin
            for (int i = 0; i < 7; i++) begin
                save_ff[i] <= nxt_save[i];
            end
            st_ff <= nxt_st;
            idx_ff <= nxt_idx;  ms_ff <= nxt_ms;  reg_sel_ff <= nxt_reg_sel;
            wr_ff <= nxt_wr;  rd_ff <= nxt_rd;  sreq_ff <= nxt_sreq;
            addr_ff <= nxt_addr;  wdata_ff <= nxt_wdata;
            susp_ff <= (nxt_st == usb_susp_pkg::FW_SLEEPING);
            busy_ff <= (nxt_st == usb_susp_pkg::FW_DRIVE_J)
                       || (nxt_st == usb_susp_pkg::FW_DRIVE_K);
        end
    end

    assign link.reg_wr     = wr_ff;
    assign link.reg_rd     = rd_ff;
    assign link.reg_addr   = addr_ff;
    assign link.reg_wdata  = wdata_ff;
    assign link.sleep_req  = sreq_ff;
    assign link.sleep_mode = sleep_mode_sel;
    assign suspended       = susp_ff;
    assign resume_busy     = busy_ff;
endmodule
`default_nettype wire

// ---- logic/usb_susp_consts.svh ----
// Constants for the USB suspend, wake and resume control block.
`ifndef USB_SUSP_CONSTS_SVH
`define USB_SUSP_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices on the firmware register port
// ----------------------------------------------------------------
`define SR_IDX_CTL_FIRST   4'h0
`define SR_IDX_CTL_SECOND  4'h1
`define SR_IDX_XCVR_FIRST  4'h2
`define SR_IDX_XCVR_SECOND 4'h3
`define SR_IDX_OSC_TRIM    4'h4
`define SR_IDX_OSC_TRIM2   4'h5
`define SR_IDX_EP_CTRL     4'h6
`define SR_IDX_BUF_WPTR    4'h7
`define SR_IDX_BUF_RPTR    4'h8
`define SR_IDX_BUF_DATA    4'h9
`define SR_IDX_EP_COUNT    4'hA
`define SR_IDX_EP0_DATA    4'hB
`define SR_IDX_FRAME       4'hC
`define SR_NREG            4'hD
`define SR_FIRST_VOLATILE  4'h6
`define SR_NVOLATILE       4'h7
`define SR_REG_RESET       8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SR_CTL0_WAKE_EN_BIT 7
`define SR_CTL1_REG_SEL_BIT 0
`define SR_CTL1_ACTIVITY_BIT 3
`define SR_XCVR0_OVR_EN_BIT 7
`define SR_XCVR0_LEVEL_BIT  6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SR_CLK_PERIOD_NS 25
`define SR_NS_PER_MS     1000000
`define SR_MS_CYCLES     (`SR_NS_PER_MS / `SR_CLK_PERIOD_NS)
`define SR_IDLE_MS       4'h3
`define SR_K_MIN_MS      4'h1
`define SR_K_MAX_MS      4'hF
`define SR_K_HOLD_MS     4'hA

`endif

// ---- logic/usb_susp_pkg.sv ----
// Types shared by both ends of the USB suspend control link.
package usb_susp_pkg;
    typedef enum logic [1:0] {
        SLEEP_STANDBY  = 2'b00,
        SLEEP_TWO_WIRE = 2'b01,
        SLEEP_DEEP     = 2'b10
    } sleep_mode_t;

    typedef enum logic {
        DEV_RUN   = 1'b0,
        DEV_SLEEP = 1'b1
    } dev_state_t;

    typedef enum logic [3:0] {
        FW_INIT_CTL0 = 4'b0000,
        FW_INIT_CTL1 = 4'b0001,
        FW_IDLE      = 4'b0010,
        FW_POLL_WAIT = 4'b0011,
        FW_POLL_CLR  = 4'b0100,
        FW_SAVE_WAIT = 4'b0101,
        FW_SLEEP_REQ = 4'b0110,
        FW_SLEEPING  = 4'b0111,
        FW_RESTORE   = 4'b1000,
        FW_DRIVE_J   = 4'b1001,
        FW_DRIVE_K   = 4'b1010,
        FW_RELEASE   = 4'b1011,
        FW_POLL_RD   = 4'b1100,
        FW_SAVE_RD   = 4'b1101
    } fw_state_t;
endpackage

// ---- logic/usb_susp_if.sv ----
// Link between the suspend control device and its firmware agent.
`timescale 1ns/1ps
`default_nettype none
interface usb_susp_if;
    logic                      reg_wr;
    logic                      reg_rd;
    logic [3:0]                reg_addr;
    logic [7:0]                reg_wdata;
    logic [7:0]                reg_rdata;
    logic                      reg_rvalid;
    logic                      sleep_req;
    usb_susp_pkg::sleep_mode_t sleep_mode;
    logic                      asleep;
    logic                      wake_irq;

    modport device (
        input  reg_wr, reg_rd, reg_addr, reg_wdata, sleep_req, sleep_mode,
        output reg_rdata, reg_rvalid, asleep, wake_irq
    );
    modport firmware (
        output reg_wr, reg_rd, reg_addr, reg_wdata, sleep_req, sleep_mode,
        input  reg_rdata, reg_rvalid, asleep, wake_irq
    );
endinterface
`default_nettype wire

// ---- logic/ms_tick_divider.sv ----
// Divider that emits a one-cycle enable pulse every DIVIDE clocks.
`timescale 1ns/1ps
`default_nettype none
module ms_tick_divider #(
    parameter int DIVIDE = 40000
) (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    output logic      tick
);
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic        tick_ff;
    logic        nxt_tick;

    // Counts down and pulses when the count wraps.
    always_comb begin
        nxt_tick = 1'b0;
        nxt_cnt  = cnt_ff - 32'h00000001;
        if (cnt_ff == 32'h00000000) begin
            nxt_cnt  = 32'(DIVIDE - 1);
            nxt_tick = 1'b1;
        end
    end

    // Registers the counter and the pulse.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_ff  <= 32'(DIVIDE - 1);
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule
`default_nettype wire

// ---- logic/usb_suspend_resume_control.sv ----
// Device end: USB suspend, wake, retention, resume override and regulator mode.
//
// Contract
// - Firmware polls activity, suspends after idle interval.
// - Firmware clears activity flag after reading it set.
// - Two-wire standby sleep keeps every register.
// - Firmware never changes regulator settings at sleep.
// - Sleep moves regulator to matching low power.
// - Control, transceiver, trim registers always retained.
// - Endpoint, buffer, count, frame registers reset after wake from standby or deep sleep.
// - Firmware saves and restores volatile registers.
// - Wake interrupt asserts only while asleep; the code pulses it in the same cycle in which asleep falls.
// - Bus activity wakes from all three sleeps.
// - D+ low at sleep entry gives immediate wake.
// - Firmware drives J briefly with override.
// - Firmware then drives K for 1-15 ms.
// - Firmware ends resume by clearing override.
// - Regulator select bit picks regulating or passthrough.
// - Firmware picks passthrough for 3.3V supply.
// - Power-up gives passthrough and tristated pins.
`include "usb_susp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module usb_suspend_resume_control (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    usb_susp_if.device      link,
    input  wire logic       dp_in,
    input  wire logic       dm_in,
    output logic            dp_out,
    output logic            dp_oe,
    output logic            dm_out,
    output logic            dm_oe,
    output logic            regulator_regulating,
    output logic            regulator_low_power
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0]                regs_ff [0:12];
    logic [7:0]                nxt_regs [0:12];
    usb_susp_pkg::dev_state_t  state_ff;
    usb_susp_pkg::dev_state_t  nxt_state;
    usb_susp_pkg::sleep_mode_t mode_ff;
    usb_susp_pkg::sleep_mode_t nxt_mode;
    logic                      early_wake_ff;
    logic                      nxt_early_wake;
    logic [1:0]                line_prev_ff;
    logic                      wake_irq_ff;
    logic                      nxt_wake_irq;
    logic [7:0]                rdata_ff;
    logic [7:0]                nxt_rdata;
    logic                      rvalid_ff;
    logic                      nxt_rvalid;
    logic                      dp_out_ff;
    logic                      dp_oe_ff;
    logic                      dm_out_ff;
    logic                      dm_oe_ff;
    logic                      reg_mode_ff;
    logic                      low_power_ff;
    logic                      line_change;
    logic                      addr_ok;
    logic                      wake_en;
    logic [7:0]                ctl1_cur;
    logic [7:0]                xcvr_nxt;

    // ----------------------------------------------------------------
    // Bus line monitor
    // ----------------------------------------------------------------

    // Any change of either data line since the last cycle counts as activity.
    assign line_change = ({dp_in, dm_in} != line_prev_ff);
    assign addr_ok     = (link.reg_addr < `SR_NREG);
    assign wake_en     = regs_ff[`SR_IDX_CTL_FIRST][`SR_CTL0_WAKE_EN_BIT];
    assign ctl1_cur    = regs_ff[`SR_IDX_CTL_SECOND];

    // ----------------------------------------------------------------
    // Register file and sleep sequencing
    // ----------------------------------------------------------------

    // Computes register writes, reads, the activity flag and sleep transitions.
    always_comb begin
        for (int i = 0; i < 13; i++) begin
            nxt_regs[i] = regs_ff[i];
        end
        nxt_state      = state_ff;
        nxt_mode       = mode_ff;
        nxt_early_wake = early_wake_ff;
        nxt_wake_irq   = 1'b0;
        nxt_rvalid     = 1'b0;
        nxt_rdata      = rdata_ff;

        // Firmware only runs while the device is awake.
        if (state_ff == usb_susp_pkg::DEV_RUN && link.reg_wr && addr_ok) begin
            nxt_regs[link.reg_addr] = link.reg_wdata;
        end
        if (state_ff == usb_susp_pkg::DEV_RUN && link.reg_rd) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = addr_ok ? regs_ff[link.reg_addr] : `SR_REG_RESET;
        end

        // Writing zero clears the flag, writing one keeps it; a new edge wins.
        nxt_regs[`SR_IDX_CTL_SECOND][`SR_CTL1_ACTIVITY_BIT] =
            (ctl1_cur[`SR_CTL1_ACTIVITY_BIT]
             & ~(state_ff == usb_susp_pkg::DEV_RUN && link.reg_wr
                 && link.reg_addr == `SR_IDX_CTL_SECOND
                 && !link.reg_wdata[`SR_CTL1_ACTIVITY_BIT]))
            | line_change;

        case (state_ff)
            usb_susp_pkg::DEV_RUN: begin
                if (link.sleep_req) begin
                    nxt_state      = usb_susp_pkg::DEV_SLEEP;
                    nxt_mode       = link.sleep_mode;
                    nxt_early_wake = ~dp_in;
                end
            end
            usb_susp_pkg::DEV_SLEEP: begin
                // Wake fires from every sleep mode, and only from sleep.
                if (wake_en && (line_change || early_wake_ff)) begin
                    nxt_state      = usb_susp_pkg::DEV_RUN;
                    nxt_wake_irq   = 1'b1;
                    nxt_early_wake = 1'b0;
                    // Two-wire standby keeps everything; other modes lose the
                    // endpoint and buffer group, the control group stays.
                    if (mode_ff != usb_susp_pkg::SLEEP_TWO_WIRE) begin
                        for (int i = 6; i < 13; i++) begin
                            nxt_regs[i] = `SR_REG_RESET;
                        end
                    end
                end
            end
            default: begin
                nxt_state = usb_susp_pkg::DEV_RUN;
            end
        endcase
    end

    // Registers the register file and sleep state.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 13; i++) begin
                regs_ff[i] <= `SR_REG_RESET;
            end
            state_ff      <= usb_susp_pkg::DEV_RUN;
            mode_ff       <= usb_susp_pkg::SLEEP_STANDBY;
            early_wake_ff <= 1'b0;
            // Starts at the idle J level so that release of reset is no edge.
            line_prev_ff  <= 2'h2;
            wake_irq_ff   <= 1'b0;
            rdata_ff      <= 8'h00;
            rvalid_ff     <= 1'b0;
        end else begin
            // Indices 0 to 5 are never cleared by a wake.
            for (int i = 0; i < 13; i++) begin
                regs_ff[i] <= nxt_regs[i];
            end
            state_ff      <= nxt_state;
            mode_ff       <= nxt_mode;
            early_wake_ff <= nxt_early_wake;
            line_prev_ff  <= {dp_in, dm_in};
            wake_irq_ff   <= nxt_wake_irq;
            rdata_ff      <= nxt_rdata;
            rvalid_ff     <= nxt_rvalid;
        end
    end

    // ----------------------------------------------------------------
    // Transceiver override and regulator
    // ----------------------------------------------------------------

    // The override pair forces J (level high) or K (level low) on the lines.
    assign xcvr_nxt = nxt_regs[`SR_IDX_XCVR_FIRST];

    // Registers pin drive and regulator mode from the next register values.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            dp_out_ff    <= 1'b0;
            dp_oe_ff     <= 1'b0;
            dm_out_ff    <= 1'b0;
            dm_oe_ff     <= 1'b0;
            reg_mode_ff  <= 1'b0;
            low_power_ff <= 1'b0;
        end else begin
            dp_oe_ff     <= xcvr_nxt[`SR_XCVR0_OVR_EN_BIT];
            dm_oe_ff     <= xcvr_nxt[`SR_XCVR0_OVR_EN_BIT];
            dp_out_ff    <= xcvr_nxt[`SR_XCVR0_LEVEL_BIT];
            dm_out_ff    <= ~xcvr_nxt[`SR_XCVR0_LEVEL_BIT];
            reg_mode_ff  <= nxt_regs[`SR_IDX_CTL_SECOND][`SR_CTL1_REG_SEL_BIT];
            // The selected mode is kept; only its low-power variant is chosen.
            low_power_ff <= (nxt_state == usb_susp_pkg::DEV_SLEEP);
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign link.reg_rdata       = rdata_ff;
    assign link.reg_rvalid      = rvalid_ff;
    assign link.asleep          = (state_ff == usb_susp_pkg::DEV_SLEEP);
    assign link.wake_irq        = wake_irq_ff;
    assign dp_out               = dp_out_ff;
    assign dp_oe                = dp_oe_ff;
    assign dm_out               = dm_out_ff;
    assign dm_oe                = dm_oe_ff;
    assign regulator_regulating = reg_mode_ff;
    assign regulator_low_power  = low_power_ff;
endmodule
`default_nettype wire

// ---- testbench/usb_susp_asserts.sv ----
// Checker for the suspend link between the device and its firmware agent.
`timescale 1ns/1ps
`default_nettype none
module usb_susp_asserts (
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic       reg_rd,
    input wire logic       reg_rvalid,
    input wire logic       sleep_req,
    input wire logic       asleep,
    input wire logic       wake_irq
);
    // ----------------------------------------------------------------
    // Link timing relations
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_irq_in_sleep: assert property (wake_irq |-> $past(asleep) && !asleep)
        else $error("wake pulse outside sleep");
    a_irq_one_cycle: assert property (wake_irq |=> !wake_irq)
        else $error("wake pulse too long");
    a_fall_has_irq: assert property ($fell(asleep) |-> wake_irq)
        else $error("sleep left without wake pulse");
    a_sleep_taken: assert property (sleep_req && !asleep |=> asleep)
        else $error("sleep request not taken");
    a_no_req_asleep: assert property (asleep |-> !sleep_req)
        else $error("sleep request while asleep");
    a_read_answer: assert property (reg_rd && !asleep |=> reg_rvalid)
        else $error("read without answer");
    a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd) && !$past(asleep))
        else $error("answer without read");
    a_reset_clean: assert property ($fell(sys_rst) |-> !asleep && !reg_rvalid)
        else $error("state not clear after reset");
    // Main scenarios reached.
    c_wake: cover property (wake_irq);
    c_sleep: cover property ($rose(asleep));
    c_read: cover property (reg_rvalid);
endmodule
`default_nettype wire

// ---- testbench/usb_suspend_resume_control_tb_top.sv ----
// Self-checking bench for the suspend control device and its firmware agent.
`timescale 1ns/1ps
`default_nettype none
module usb_suspend_resume_control_tb_top;
    // ----------------------------------------------------------------
    // Signals, rows and instances
    // ----------------------------------------------------------------
    localparam int MS = 10;
    typedef struct packed {logic s5; logic [1:0] md; logic rg;} row_t;
    row_t                      rows [3] = '{'{1, 0, 1}, '{0, 1, 0}, '{1, 2, 1}};
    logic                      sys_clk, sys_rst, dp_host, dm_host, supply_is_5v;
    logic                      remote_wake_req, suspended, resume_busy, dp_out, dp_oe;
    logic                      dm_out, dm_oe, regulator_regulating, regulator_low_power;
    wire logic                 dp_in, dm_in;
    usb_susp_pkg::sleep_mode_t sleep_mode_sel;
    int                        miscompares, checked, cycles, j, k;
    // The wire level follows the device while it drives, else the host.
    assign dp_in = dp_oe ? dp_out : dp_host;
    assign dm_in = dm_oe ? dm_out : dm_host;
    usb_susp_if link ();
    usb_suspend_resume_control usb_suspend_resume_control_i (.sys_clk, .sys_rst, .link,
        .dp_in, .dm_in, .dp_out, .dp_oe, .dm_out, .dm_oe, .regulator_regulating,
        .regulator_low_power);
    usb_suspend_firmware_agent #(.MS_CYCLES(MS)) usb_suspend_firmware_agent_i (.sys_clk,
        .sys_rst, .link, .supply_is_5v, .sleep_mode_sel, .remote_wake_req, .suspended,
        .resume_busy);
    usb_susp_asserts usb_susp_asserts_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_rd(link.reg_rd), .reg_rvalid(link.reg_rvalid), .sleep_req(link.sleep_req),
        .asleep(link.asleep), .wake_irq(link.wake_irq));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits for agent sleep (0), wake pulse (1) or resume drive (2).
    task automatic wait_for(input int sel, input int lim);
        int n;
        n = 0;
        #1;
        while (!(sel == 0 ? suspended : sel == 1 ? link.wake_irq : resume_busy) && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(n < lim, 1);
    endtask
    task automatic do_reset;
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        chk({dp_oe, dm_oe, regulator_regulating, link.asleep}, 8'h00);
    endtask
    task automatic end_sim;
        if (miscompares == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Clock, timeout and scenarios
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // A hang counts as a mismatch and closes the run.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_sim;
        end
    end
    initial begin
        {sys_rst, dp_host, dm_host, supply_is_5v, remote_wake_req} = 5'h1A;
        sleep_mode_sel = usb_susp_pkg::SLEEP_STANDBY;
        {miscompares, checked, cycles} = '0;
        foreach (rows[i]) begin
            @(posedge sys_clk);
            supply_is_5v <= rows[i].s5;
            sleep_mode_sel <= usb_susp_pkg::sleep_mode_t'(rows[i].md);
            do_reset;
            wait_for(0, 400);
            @(posedge sys_clk);
            #1;
            chk({regulator_regulating, regulator_low_power}, {rows[i].rg, 1'b1});
            @(posedge sys_clk);
            dp_host <= 1'b0;
            @(posedge sys_clk);
            dp_host <= 1'b1;
            wait_for(1, 4);
            chk({regulator_regulating, regulator_low_power}, {rows[i].rg, 1'b0});
        end
        // D+ held low at sleep entry gives a prompt wake.
        @(posedge sys_clk);
        dp_host <= 1'b0;
        wait_for(0, 400);
        wait_for(1, 4);
        // Remote wake: J first, then K for a bounded time, then release.
        @(posedge sys_clk);
        dp_host <= 1'b1;
        do_reset;
        remote_wake_req <= 1'b1;
        wait_for(2, 400);
        remote_wake_req <= 1'b0;
        {j, k} = '0;
        while (resume_busy === 1'b1) begin
            if (dp_oe && dm_oe && dp_out && !dm_out && k == 0) j = 1;
            if (dp_oe && dm_oe && !dp_out && dm_out) k++;
            @(posedge sys_clk);
            #1;
        end
        repeat (3) @(posedge sys_clk);
        #1;
        chk(j, 1);
        chk(k >= MS && k <= 15 * MS, 1);
        chk({dp_oe, dm_oe}, 8'h00);
        end_sim;
    end
endmodule
`default_nettype wire
